// ===== iwdg_pkg.sv
// Constants for the independent watchdog register block
package iwdg_pkg;

   // Register byte offsets
   localparam logic [3:0] IWDG_OFS_CMD    = 4'h0;
   localparam logic [3:0] IWDG_OFS_DIV    = 4'h4;
   localparam logic [3:0] IWDG_OFS_RELOAD = 4'h8;
   localparam logic [3:0] IWDG_OFS_STATUS = 4'hc;

   // Command word codes
   localparam logic [15:0] IWDG_KEY_UNLOCK  = 16'h5555;
   localparam logic [15:0] IWDG_KEY_REFRESH = 16'haaaa;
   localparam logic [15:0] IWDG_KEY_START   = 16'hcccc;

   // Field widths and positions
   localparam int          IWDG_DIV_W     = 3;
   localparam int          IWDG_CNT_W     = 12;
   localparam int          IWDG_PRE_W     = 8;
   localparam int          IWDG_ST_DIV    = 0;
   localparam int          IWDG_ST_RELOAD = 1;

   // Reset values
   localparam logic [2:0]  IWDG_DIV_RST    = 3'h0;
   localparam logic [11:0] IWDG_RELOAD_RST = 12'hfff;
   localparam logic [11:0] IWDG_CNT_ZERO   = 12'h000;
   localparam logic [31:0] IWDG_RD_ZERO    = 32'h0000_0000;

   // Divider codes: 000 is /4, each step doubles, 110 and 111 are /256
   localparam logic [2:0]  IWDG_DIV_MAX   = 3'h6;
   localparam logic [7:0]  IWDG_DIV_BASE  = 8'h03;

   // Byte lanes that carry the low halfword
   localparam logic [3:0]  IWDG_STRB_LO   = 4'h3;

   // Counter run states
   typedef enum logic [1:0] {
      IWDG_IDLE = 2'b01,
      IWDG_RUN  = 2'b10
   } iwdg_state_t;

endpackage

// ===== iwdg_regs.sv
// Independent watchdog: APB registers, update handshake and down counter
//
// Local design decision: register access over APB.
`timescale 1ns/1ps

module iwdg_regs
   import iwdg_pkg::*;
(
   // Clock and resets
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        standby_resetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [3:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Watchdog clock and option
   input  wire logic        lsi_clk_in,
   input  wire logic        hw_watchdog_opt,
   // Watchdog outputs
   output logic             wdg_reset_req,
   output logic             wdg_running
);

   // Divider code to prescale terminal count; ones fill up from the /4
   // mask so code 110 reaches all ones without a ninth bit
   function automatic logic [7:0] div_last(input logic [2:0] code);
      logic [2:0] c;
      c = (code > IWDG_DIV_MAX) ? IWDG_DIV_MAX : code;
      div_last = ~((~IWDG_DIV_BASE) << c);
   endfunction

   // Command word decode from a write of the low halfword
   function automatic logic is_key(input logic [31:0] d,
                                   input logic [15:0] key);
      is_key = (d[15:0] == key);
   endfunction

   // Bus decode
   logic setup_ph;
   logic acc_wr;
   logic lo_half;
   logic hit_cmd;
   logic hit_div;
   logic hit_reload;
   logic hit_status;
   logic mapped;

   // Register state
   logic                  unlocked_q;
   logic [IWDG_DIV_W-1:0] div_shadow_q;
   logic [IWDG_CNT_W-1:0] reload_shadow_q;
   logic                  div_pend_q;
   logic                  reload_pend_q;
   logic [31:0]           prdata_q;
   logic                  slverr_q;

   // Watchdog side state
   logic                  lsi_s1_q;
   logic                  lsi_s2_q;
   logic                  lsi_s3_q;
   logic                  lsi_tick;
   logic [IWDG_DIV_W-1:0] div_act_q;
   logic [IWDG_CNT_W-1:0] reload_act_q;
   logic [IWDG_PRE_W-1:0] pre_q;
   logic [IWDG_CNT_W-1:0] cnt_q;
   logic                  hw_opt_q;
   logic                  strap_done_q;
   logic                  wdg_rst_q;
   logic                  refresh_req_q;
   iwdg_state_t           state_q;
   logic                  any_rst;

   // Combined reset for registers that also clear in standby
   assign any_rst = !resetn || !standby_resetn;

   // Address decode; only the low nibble is routed here
   always_comb
   begin
      hit_cmd    = 1'b0;
      hit_div    = 1'b0;
      hit_reload = 1'b0;
      hit_status = 1'b0;
      if (paddr == IWDG_OFS_CMD)
         hit_cmd = 1'b1;
      else if (paddr == IWDG_OFS_DIV)
         hit_div = 1'b1;
      else if (paddr == IWDG_OFS_RELOAD)
         hit_reload = 1'b1;
      else if (paddr == IWDG_OFS_STATUS)
         hit_status = 1'b1;
   end

   assign mapped   = hit_cmd | hit_div | hit_reload | hit_status;
   assign setup_ph = psel && !penable;
   // Write commits at the access edge; no wait states
   assign acc_wr   = psel && penable && pwrite && mapped;
   // Low halfword or word writes both fill the low lanes
   assign lo_half  = ((pstrb & IWDG_STRB_LO) == IWDG_STRB_LO);
   assign pready   = 1'b1;
   assign pslverr  = slverr_q;
   assign prdata   = prdata_q;

   // Read data captured in setup so it stands from a flip-flop
   always_ff @(posedge clk)
   begin
      if (!resetn)
         prdata_q <= IWDG_RD_ZERO;
      else if (setup_ph && !pwrite)
      begin
         prdata_q <= IWDG_RD_ZERO; // Reserved bits read zero
         if (hit_cmd)
            prdata_q <= IWDG_RD_ZERO; // Write-only
         else if (hit_div)
            prdata_q[IWDG_DIV_W-1:0] <= div_shadow_q;
         else if (hit_reload)
            prdata_q[IWDG_CNT_W-1:0] <= reload_shadow_q;
         else if (hit_status)
         begin
            prdata_q[IWDG_ST_DIV]    <= div_pend_q;
            prdata_q[IWDG_ST_RELOAD] <= reload_pend_q;
         end
      end
   end

   // Error answer for unmapped addresses
   always_ff @(posedge clk)
   begin
      if (!resetn)
         slverr_q <= 1'b0;
      else if (setup_ph)
         slverr_q <= !mapped;
   end

   // Write protection latch driven by the command word
   always_ff @(posedge clk)
   begin
      if (any_rst)
         unlocked_q <= 1'b0;
      else if (acc_wr && hit_cmd && lo_half)
         unlocked_q <= is_key(pwdata, IWDG_KEY_UNLOCK);
   end

   // Refresh request; the counter side takes it on the next cycle
   always_ff @(posedge clk)
   begin
      if (any_rst)
         refresh_req_q <= 1'b0;
      else
         refresh_req_q <= acc_wr && hit_cmd && lo_half
                          && is_key(pwdata, IWDG_KEY_REFRESH);
   end

   // Divider select shadow: protected and refused while pending
   always_ff @(posedge clk)
   begin
      if (!resetn)
         div_shadow_q <= IWDG_DIV_RST;
      else if (acc_wr && hit_div && lo_half && unlocked_q
               && !div_pend_q)
         div_shadow_q <= pwdata[IWDG_DIV_W-1:0];
   end

   // Reload shadow; standby reset restores all ones too
   always_ff @(posedge clk)
   begin
      if (any_rst)
         reload_shadow_q <= IWDG_RELOAD_RST;
      else if (acc_wr && hit_reload && lo_half && unlocked_q
               && !reload_pend_q)
         reload_shadow_q <= pwdata[IWDG_CNT_W-1:0];
   end

   // Divider update flag: set by a taken write, cleared when the
   // watchdog side copies the value on its next tick. Writes are
   // refused while set, so a set never meets a clear.
   always_ff @(posedge clk)
   begin
      if (!resetn)
         div_pend_q <= 1'b0; // Held across standby
      else if (acc_wr && hit_div && lo_half && unlocked_q
               && !div_pend_q)
         div_pend_q <= 1'b1;
      else if (lsi_tick)
         div_pend_q <= 1'b0;
   end

   // Reload update flag, same handshake
   always_ff @(posedge clk)
   begin
      if (!resetn)
         reload_pend_q <= 1'b0;
      else if (acc_wr && hit_reload && lo_half && unlocked_q
               && !reload_pend_q)
         reload_pend_q <= 1'b1;
      else if (lsi_tick)
         reload_pend_q <= 1'b0;
   end

   // Low-speed clock pin: two-stage synchroniser, then edge detect
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         lsi_s1_q <= 1'b0;
         lsi_s2_q <= 1'b0;
         lsi_s3_q <= 1'b0;
      end
      else
      begin
         lsi_s1_q <= lsi_clk_in;
         lsi_s2_q <= lsi_s1_q;
         lsi_s3_q <= lsi_s2_q;
      end
   end

   // One-cycle enable per low-speed rising edge
   assign lsi_tick = lsi_s2_q && !lsi_s3_q;

   // Active copies on the watchdog side, loaded only on a tick
   always_ff @(posedge clk)
   begin
      if (!resetn)
         div_act_q <= IWDG_DIV_RST;
      else if (lsi_tick && div_pend_q)
         div_act_q <= div_shadow_q;
   end

   always_ff @(posedge clk)
   begin
      if (any_rst)
         reload_act_q <= IWDG_RELOAD_RST;
      else if (lsi_tick && reload_pend_q)
         reload_act_q <= reload_shadow_q;
   end

   // Hardware option strap caught once after reset release
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         hw_opt_q     <= 1'b0;
         strap_done_q <= 1'b0;
      end
      else if (!strap_done_q)
      begin
         hw_opt_q     <= hw_watchdog_opt;
         strap_done_q <= 1'b1;
      end
   end

   // Run state: once running only a reset stops it
   always_ff @(posedge clk)
   begin
      if (any_rst)
         state_q <= IWDG_IDLE;
      else
         case (state_q)
            IWDG_IDLE:
               if ((acc_wr && hit_cmd && lo_half
                    && is_key(pwdata, IWDG_KEY_START))
                   || hw_opt_q)
                  state_q <= IWDG_RUN;
            IWDG_RUN:
               state_q <= IWDG_RUN;
            default:
               state_q <= IWDG_IDLE;
         endcase
   end

   assign wdg_running = (state_q == IWDG_RUN);

   // Prescale counter; tracks the active divider code
   always_ff @(posedge clk)
   begin
      if (any_rst || !wdg_running || refresh_req_q)
         pre_q <= '0;
      else if (lsi_tick)
      begin
         if (pre_q >= div_last(div_act_q))
            pre_q <= '0;
         else
            pre_q <= pre_q + 8'h01;
      end
   end

   // Down counter: refresh wins over a count step
   always_ff @(posedge clk)
   begin
      if (any_rst)
         cnt_q <= IWDG_RELOAD_RST;
      else if (refresh_req_q)
         cnt_q <= reload_act_q;
      else if (wdg_running && lsi_tick
               && pre_q >= div_last(div_act_q)
               && cnt_q != IWDG_CNT_ZERO)
         cnt_q <= cnt_q - 12'h001;
   end

   // Reset request held from zero until the system resets us
   always_ff @(posedge clk)
   begin
      if (any_rst)
         wdg_rst_q <= 1'b0;
      else if (wdg_running && cnt_q == IWDG_CNT_ZERO)
         wdg_rst_q <= 1'b1;
   end

   assign wdg_reset_req = wdg_rst_q;

endmodule // iwdg_regs

// ===== iwdg_regs_sva.sv
// Port assertions for the watchdog register block
`timescale 1ns/1ps
module iwdg_regs_chk
   import iwdg_pkg::*;
(
   // Clock and resets
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        standby_resetn,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [3:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Watchdog
   input wire logic        wdg_reset_req,
   input wire logic        wdg_running
);
   // Standby reset clears the run state too, so it also disables
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn || !standby_resetn);

   // Access phase, read of one offset, and a full command write
   sequence acc_s;
      psel && penable;
   endsequence
   sequence rd_s(a);
      psel && penable && !pwrite && paddr == a;
   endsequence
   sequence cmd_s(k);
      psel && penable && pwrite && paddr == IWDG_OFS_CMD
         && pstrb[1:0] == 2'b11 && pwdata[15:0] == k;
   endsequence

   zero_wait_a: assert property (acc_s |-> pready)
      else $error("access phase not answered");
   unmapped_err_a: assert property (acc_s ##0 paddr[1:0] != 2'h0 |-> pslverr)
      else $error("unaligned access without error");
   mapped_ok_a: assert property (acc_s ##0 paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("mapped access flagged as error");
   cmd_zero_a: assert property (rd_s(IWDG_OFS_CMD) |-> prdata == IWDG_RD_ZERO)
      else $error("command word read not zero");
   div_bits_a: assert property (rd_s(IWDG_OFS_DIV) |-> prdata[31:3] == 29'h0)
      else $error("divider upper bits not zero");
   rld_bits_a: assert property (rd_s(IWDG_OFS_RELOAD) |-> prdata[31:12] == 20'h0)
      else $error("reload upper bits not zero");
   sts_bits_a: assert property (rd_s(IWDG_OFS_STATUS) |-> prdata[31:2] == 30'h0)
      else $error("status upper bits not zero");
   start_run_a: assert property (cmd_s(IWDG_KEY_START) |=> wdg_running)
      else $error("start code did not start counter");
   run_hold_a: assert property (wdg_running |=> wdg_running)
      else $error("counter stopped without reset");
   req_hold_a: assert property (wdg_reset_req |=> wdg_reset_req)
      else $error("reset request dropped");
endmodule // iwdg_regs_chk

bind iwdg_regs iwdg_regs_chk u_chk (.clk(clk), .resetn(resetn),
   .standby_resetn(standby_resetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .wdg_reset_req(wdg_reset_req), .wdg_running(wdg_running));

// ===== iwdg_regs_tb_top.sv
// Self-checking bench for the watchdog register block
`timescale 1ns/1ps
module iwdg_regs_tb_top
   import iwdg_pkg::*;
;
   typedef struct {
      logic        wr;
      logic [3:0]  a;
      logic [31:0] d;
      logic [3:0]  s;
      logic [31:0] e;
   } iwdg_row_t;
   logic        clk, resetn, standby_resetn, psel, penable, pwrite;
   logic [3:0]  paddr, pstrb;
   logic [31:0] pwdata, prdata, rd_q;
   logic        pready, pslverr, err_q, lsi, hw_opt, req, run;
   int          errors, total_checks;
   iwdg_row_t   rows [13];

   // Free-running 100 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   iwdg_regs DUT (.clk(clk), .resetn(resetn),
      .standby_resetn(standby_resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .lsi_clk_in(lsi), .hw_watchdog_opt(hw_opt),
      .wdg_reset_req(req), .wdg_running(run));

   // Compare tasks: words and single flags
   task automatic check(logic [31:0] got, logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(logic got, logic exp);
      check({31'h0, got}, {31'h0, exp});
   endtask

   // One APB transfer; request held until pready is seen high
   task automatic apb(logic w, logic [3:0] a, logic [31:0] d,
                      logic [3:0] s);
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd_q = prdata;
      err_q = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(logic [3:0] a, logic [31:0] e);
      apb(1'b0, a, 32'h0, 4'hf);
      check(rd_q, e);
   endtask

   // Slow clock edges, 4 cycles high and low, plus sync slack
   task automatic tick(int n);
      repeat (n)
      begin
         repeat (4) @(posedge clk);
         lsi <= 1'b1;
         repeat (4) @(posedge clk);
         lsi <= 1'b0;
      end
      repeat (4) @(posedge clk);
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Hang guard, well beyond the few thousand cycles the tests need
   initial
   begin
      repeat (20000) @(posedge clk);
      errors++;
      complete_run();
   end

   // Main sequence
   initial
   begin
      {psel, penable, pwrite, lsi, hw_opt, paddr, pstrb, pwdata} = '0;
      resetn = 1'b0;
      standby_resetn = 1'b0;
      rows = '{
         '{1'b0, 4'h0, 32'h0, 4'hf, 32'h0},
         '{1'b0, 4'h4, 32'h0, 4'hf, 32'h0},
         '{1'b0, 4'h8, 32'h0, 4'hf, 32'hfff},
         '{1'b0, 4'hc, 32'h0, 4'hf, 32'h0},
         '{1'b1, 4'h4, 32'h5, 4'hf, 32'h0},
         '{1'b0, 4'h4, 32'h0, 4'hf, 32'h0},
         '{1'b1, 4'h0, 32'h5555, 4'hf, 32'h0},
         '{1'b1, 4'h8, 32'hc00, 4'hc, 32'h0},
         '{1'b0, 4'hc, 32'h0, 4'hf, 32'h0},
         '{1'b1, 4'h8, 32'h123, 4'h3, 32'h0},
         '{1'b0, 4'h8, 32'h0, 4'hf, 32'h123},
         '{1'b0, 4'hc, 32'h0, 4'hf, 32'h2},
         '{1'b0, 4'h0, 32'h0, 4'hf, 32'h0}};
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      standby_resetn <= 1'b1;
      foreach (rows[i])
      begin
         apb(rows[i].wr, rows[i].a, rows[i].d, rows[i].s);
         if (!rows[i].wr)
            check(rd_q, rows[i].e);
      end
      $display("table done");
      // Second divider write is refused while the first is crossing
      tick(2);
      rd(4'hc, 32'h0);
      rd(4'h8, 32'h123);
      apb(1'b1, 4'h4, 32'h6, 4'hf);
      rd(4'hc, 32'h1);
      apb(1'b1, 4'h4, 32'h0, 4'hf);
      tick(2);
      rd(4'h4, 32'h6);
      apb(1'b1, 4'h4, 32'h0, 4'hf);
      apb(1'b1, 4'h8, 32'h2, 4'hf);
      tick(2);
      rd(4'hc, 32'h0);
      $display("update flags done");
      // Reload 2 at /4: no expiry in 4 ticks, expiry within 9
      apb(1'b1, 4'h0, 32'haaaa, 4'hf);
      apb(1'b1, 4'h0, 32'hcccc, 4'hf);
      tick(4);
      chk_bit(run, 1'b1);
      chk_bit(req, 1'b0);
      tick(5);
      chk_bit(req, 1'b1);
      apb(1'b1, 4'h8, 32'h5, 4'hf);
      rd(4'h8, 32'h2);
      apb(1'b0, 4'h2, 32'h0, 4'hf);
      chk_bit(err_q, 1'b1);
      $display("counter done");
      // Standby reset with a divider transfer still pending
      apb(1'b1, 4'h0, 32'h5555, 4'hf);
      apb(1'b1, 4'h4, 32'h5, 4'hf);
      standby_resetn <= 1'b0;
      repeat (2) @(posedge clk);
      standby_resetn <= 1'b1;
      rd(4'h8, 32'hfff);
      rd(4'hc, 32'h1);
      chk_bit(req, 1'b0);
      // Main reset with the hardware option strapped on
      hw_opt <= 1'b1;
      resetn <= 1'b0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      rd(4'hc, 32'h0);
      chk_bit(run, 1'b1);
      $display("resets done");
      // Code 111 acts as /256: reload 1 expires on the 256th tick
      apb(1'b1, 4'h0, 32'h5555, 4'hf);
      apb(1'b1, 4'h4, 32'h7, 4'hf);
      apb(1'b1, 4'h8, 32'h1, 4'hf);
      tick(1);
      rd(4'h4, 32'h7);
      rd(4'h8, 32'h1);
      apb(1'b1, 4'h0, 32'haaaa, 4'hf);
      tick(255);
      chk_bit(req, 1'b0);
      tick(1);
      chk_bit(req, 1'b1);
      $display("slow divider done");
      complete_run();
   end
endmodule // iwdg_regs_tb_top
